// ### pkg/drs_defs.vh
// Register map, field positions, reset values and timing for the reference-site selector
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`ifndef DRS_DEFS_VH
`define DRS_DEFS_VH

// Register byte offsets
`define DRS_CTRL_OFS        8'h00
`define DRS_STATUS_OFS      8'h04
`define DRS_IRQ_STAT_OFS    8'h08
`define DRS_IRQ_MASK_OFS    8'h0c
`define DRS_SPEED_LIM_OFS   8'h10
`define DRS_FMAX_OFS        8'h14
`define DRS_RAMP_OFS        8'h18
`define DRS_LOCAL_REF_OFS   8'h1c

// Control register fields
`define DRS_CTRL_SITE_LSB   0
`define DRS_CTRL_STRUCT_LSB 2
`define DRS_CTRL_PERM_HAND  4
`define DRS_CTRL_PERM_OFF   5
`define DRS_CTRL_PERM_AUTO  6
`define DRS_CTRL_RESET      32'h0000_0070

// Site and structure codes
`define DRS_SITE_LINKED     2'h0
`define DRS_SITE_REMOTE     2'h1
`define DRS_SITE_LOCAL      2'h2
`define DRS_STRUCT_OPEN     2'h0
`define DRS_STRUCT_CLOSED   2'h3

// Mode state codes: bit 1 = running side (hand/auto), bit 0 = off remembered
`define DRS_MODE_HAND       2'h0
`define DRS_MODE_HAND_OFF   2'h1
`define DRS_MODE_AUTO       2'h2
`define DRS_MODE_AUTO_OFF   2'h3

// Interrupt status bits
`define DRS_IRQ_MODE        0
`define DRS_IRQ_ALARM       1
`define DRS_IRQ_ALARM_CLR   2
`define DRS_IRQ_KEY_DENIED  3
`define DRS_IRQ_BITS        4

// Reset values of limit registers, and the local reference up/down key step
`define DRS_SPEED_MIN_RST   16'h0000
`define DRS_SPEED_MAX_RST   16'hffff
`define DRS_FMAX_RST        16'hffff
`define DRS_RAMP_STEP_RST   16'h0001
`define DRS_LOCAL_STEP      16'h0001

// Ramp update period
`define DRS_CLK_MHZ         125
`define DRS_RAMP_PERIOD_US  1
`define DRS_RAMP_DIV        (`DRS_CLK_MHZ * `DRS_RAMP_PERIOD_US)

`endif

// ### hdl/drs_ref_select.v
// Reference-site selector: panel keys, mode, active reference, ramp and limits
`timescale 1ns/100ps
`default_nettype none
`include "drs_defs.vh"

module drs_ref_select
#(
	parameter REF_W    = 16,
	parameter RAMP_DIV = `DRS_RAMP_DIV
)
(
	input  wire             aclk,
	input  wire             aresetn,
	// AXI4-Lite slave
	input  wire [7:0]       s_axi_awaddr,
	input  wire             s_axi_awvalid,
	output wire             s_axi_awready,
	input  wire [31:0]      s_axi_wdata,
	input  wire [3:0]       s_axi_wstrb,
	input  wire             s_axi_wvalid,
	output wire             s_axi_wready,
	output reg  [1:0]       s_axi_bresp,
	output reg              s_axi_bvalid,
	input  wire             s_axi_bready,
	input  wire [7:0]       s_axi_araddr,
	input  wire             s_axi_arvalid,
	output wire             s_axi_arready,
	output reg  [31:0]      s_axi_rdata,
	output reg  [1:0]       s_axi_rresp,
	output reg              s_axi_rvalid,
	input  wire             s_axi_rready,
	// Local operator panel keys, one-cycle pulses
	input  wire             key_hand_on,
	input  wire             key_off,
	input  wire             key_auto_on,
	input  wire             key_reset,
	input  wire             key_up,
	input  wire             key_down,
	// Remote commands from digital inputs or serial bus
	input  wire             remote_start,
	input  wire             remote_stop,
	input  wire [REF_W-1:0] remote_ref,
	// Alarm events and PID controller output
	input  wire             alarm_event,
	input  wire [REF_W-1:0] pid_out,
	// Outputs
	output reg              local_active,
	output reg              remote_active,
	output reg              pid_enable,
	output reg  [REF_W-1:0] pid_setpoint,
	output reg              motor_run,
	output reg  [REF_W-1:0] motor_ref,
	output reg              alarm_latched,
	output reg  [1:0]       mode_state,
	output wire             irq
);

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	reg  [31:0]              ctrl_r;
	reg  [`DRS_IRQ_BITS-1:0] irq_stat_r;
	reg  [`DRS_IRQ_BITS-1:0] irq_mask_r;
	reg  [REF_W-1:0]         speed_min_r;
	reg  [REF_W-1:0]         speed_max_r;
	reg  [REF_W-1:0]         fmax_r;
	reg  [REF_W-1:0]         ramp_step_r;
	reg  [REF_W-1:0]         local_ref_r;
	reg  [REF_W-1:0]         ramp_r;
	reg                      auto_run_r;
	reg  [31:0]              div_r;
	wire [1:0] site   = ctrl_r[`DRS_CTRL_SITE_LSB+1:`DRS_CTRL_SITE_LSB];
	wire [1:0] struct_sel = ctrl_r[`DRS_CTRL_STRUCT_LSB+1:`DRS_CTRL_STRUCT_LSB];
	wire       perm_hand  = ctrl_r[`DRS_CTRL_PERM_HAND];
	wire       perm_off   = ctrl_r[`DRS_CTRL_PERM_OFF];
	wire       perm_auto  = ctrl_r[`DRS_CTRL_PERM_AUTO];

	// ------------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------------
	// Address and data are caught in either order; the response waits for both.
	reg        aw_held_r;
	reg        w_held_r;
	reg [7:0]  aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	wire       aw_now = aw_held_r || (s_axi_awvalid && s_axi_awready);
	wire       w_now  = w_held_r || (s_axi_wvalid && s_axi_wready);
	wire       wr_go  = aw_now && w_now && !s_axi_bvalid;
	wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
	wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
	wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire [31:0] wbits = wr_data & wmask;
	// Every aligned offset up to the local reference is mapped, status included
	wire wr_hit   = (wr_addr <= `DRS_LOCAL_REF_OFS) && (wr_addr[1:0] == 2'h0);
	wire wr_ctrl  = wr_go && (wr_addr == `DRS_CTRL_OFS);
	wire wr_istat = wr_go && (wr_addr == `DRS_IRQ_STAT_OFS);
	wire wr_imask = wr_go && (wr_addr == `DRS_IRQ_MASK_OFS);
	wire wr_lim   = wr_go && (wr_addr == `DRS_SPEED_LIM_OFS);
	wire wr_fmax  = wr_go && (wr_addr == `DRS_FMAX_OFS);
	wire wr_ramp  = wr_go && (wr_addr == `DRS_RAMP_OFS);
	wire wr_lref  = wr_go && (wr_addr == `DRS_LOCAL_REF_OFS);
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r    <= 1'b0;
			w_held_r     <= 1'b0;
			aw_addr_r    <= 8'h00;
			w_data_r     <= 32'h0000_0000;
			w_strb_r     <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready && !wr_go)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready && !wr_go)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// Operating mode and panel keys
	// ------------------------------------------------------------------------
	wire in_auto = mode_state[1];
	wire in_off  = mode_state[0];
	wire hand_ok = key_hand_on && perm_hand;
	wire off_ok  = key_off && perm_off;
	wire auto_ok = key_auto_on && perm_auto;
	wire denied  = (key_hand_on && !perm_hand) || (key_off && !perm_off) ||
		(key_auto_on && !perm_auto);
	reg [1:0] mode_nxt;
	always @*
	begin
		mode_nxt = mode_state;
		if (hand_ok)
			mode_nxt = `DRS_MODE_HAND;
		else if (auto_ok)
			mode_nxt = `DRS_MODE_AUTO;
		else if (off_ok)
			mode_nxt = {mode_state[1], 1'b1};
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_state    <= `DRS_MODE_AUTO_OFF;
			auto_run_r    <= 1'b0;
			alarm_latched <= 1'b0;
			local_ref_r   <= {REF_W{1'b0}};
		end
		else
		begin
			mode_state <= mode_nxt;
			// Remote start and stop only count in auto mode; entering auto waits for a start
			if (mode_nxt != `DRS_MODE_AUTO || auto_ok)
				auto_run_r <= 1'b0;
			else if (remote_stop)
				auto_run_r <= 1'b0;
			else if (remote_start)
				auto_run_r <= 1'b1;
			// A new alarm wins over a reset key in the same cycle
			if (alarm_event)
				alarm_latched <= 1'b1;
			else if (key_reset)
				alarm_latched <= 1'b0;
			if (wr_lref)
				local_ref_r <= wbits[REF_W-1:0];
			else if (key_up && local_ref_r != {REF_W{1'b1}})
				local_ref_r <= local_ref_r + `DRS_LOCAL_STEP;
			else if (key_down && local_ref_r != {REF_W{1'b0}})
				local_ref_r <= local_ref_r - `DRS_LOCAL_STEP;
		end
	end

	// ------------------------------------------------------------------------
	// Active reference selection
	// ------------------------------------------------------------------------
	reg use_remote;
	always @*
	begin
		case (site)
			`DRS_SITE_LOCAL:  use_remote = 1'b0;
			`DRS_SITE_REMOTE: use_remote = 1'b1;
			default:          use_remote = in_auto;
		endcase
	end
	wire closed = use_remote && (struct_sel == `DRS_STRUCT_CLOSED);
	wire running = !in_off && !alarm_latched && (!in_auto || auto_run_r);
	wire [REF_W-1:0] chosen = closed ? pid_out : (use_remote ? remote_ref : local_ref_r);
	wire [REF_W-1:0] target = running ? chosen : {REF_W{1'b0}};

	// ------------------------------------------------------------------------
	// Ramp, speed limit and maximum frequency clamp
	// ------------------------------------------------------------------------
	// The ramp advances once per divider tick so step sizes stay small integers.
	wire tick = (div_r == RAMP_DIV - 1);
	wire [REF_W:0] up_sum = {1'b0, ramp_r} + {1'b0, ramp_step_r};
	wire [REF_W-1:0] ramp_up = (up_sum[REF_W] || up_sum[REF_W-1:0] > target) ?
		target : up_sum[REF_W-1:0];
	wire [REF_W-1:0] ramp_dn = (ramp_r - target < ramp_step_r) ? target : ramp_r - ramp_step_r;
	wire [REF_W-1:0] spd = !running ? ramp_r :
		(ramp_r < speed_min_r) ? speed_min_r :
		(ramp_r > speed_max_r) ? speed_max_r : ramp_r;
	wire [REF_W-1:0] out_ref = (spd > fmax_r) ? fmax_r : spd;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_r         <= 32'h0000_0000;
			ramp_r        <= {REF_W{1'b0}};
			motor_ref     <= {REF_W{1'b0}};
			motor_run     <= 1'b0;
			local_active  <= 1'b1;
			remote_active <= 1'b0;
			pid_enable    <= 1'b0;
			pid_setpoint  <= {REF_W{1'b0}};
		end
		else
		begin
			div_r <= tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
			if (tick)
				ramp_r <= (ramp_r < target) ? ramp_up : ramp_dn;
			motor_ref     <= out_ref;
			motor_run     <= running;
			local_active  <= !use_remote;
			remote_active <= use_remote;
			pid_enable    <= closed;
			pid_setpoint  <= closed ? remote_ref : {REF_W{1'b0}};
		end
	end

	// ------------------------------------------------------------------------
	// Configuration and interrupt registers
	// ------------------------------------------------------------------------
	wire [`DRS_IRQ_BITS-1:0] ev = {denied, key_reset && alarm_latched && !alarm_event,
		alarm_event && !alarm_latched, mode_nxt != mode_state};
	assign irq = |(irq_stat_r & irq_mask_r);
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r      <= `DRS_CTRL_RESET;
			irq_stat_r  <= {`DRS_IRQ_BITS{1'b0}};
			irq_mask_r  <= {`DRS_IRQ_BITS{1'b0}};
			speed_min_r <= `DRS_SPEED_MIN_RST;
			speed_max_r <= `DRS_SPEED_MAX_RST;
			fmax_r      <= `DRS_FMAX_RST;
			ramp_step_r <= `DRS_RAMP_STEP_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= (ctrl_r & ~wmask) | (wbits & `DRS_CTRL_RESET) |
					(wbits & 32'h0000_000f);
			// New events win over a write-one-to-clear in the same cycle
			irq_stat_r <= (irq_stat_r & ~(wr_istat ? wbits[`DRS_IRQ_BITS-1:0] :
				{`DRS_IRQ_BITS{1'b0}})) | ev;
			if (wr_imask)
				irq_mask_r <= (irq_mask_r & ~wmask[`DRS_IRQ_BITS-1:0]) |
					wbits[`DRS_IRQ_BITS-1:0];
			if (wr_lim)
			begin
				speed_min_r <= wbits[15:0];
				speed_max_r <= wbits[31:16];
			end
			if (wr_fmax)
				fmax_r <= wbits[REF_W-1:0];
			if (wr_ramp)
				ramp_step_r <= wbits[REF_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	wire       rd_hit = (s_axi_araddr <= `DRS_LOCAL_REF_OFS) && (s_axi_araddr[1:0] == 2'h0);
	reg [31:0] rd_mux;
	always @*
	begin
		case (s_axi_araddr)
			`DRS_CTRL_OFS:      rd_mux = ctrl_r & 32'h0000_007f;
			`DRS_STATUS_OFS:    rd_mux = {25'h0, pid_enable, motor_run, alarm_latched,
				remote_active, local_active, mode_state};
			`DRS_IRQ_STAT_OFS:  rd_mux = {28'h0, irq_stat_r};
			`DRS_IRQ_MASK_OFS:  rd_mux = {28'h0, irq_mask_r};
			`DRS_SPEED_LIM_OFS: rd_mux = {speed_max_r, speed_min_r};
			`DRS_FMAX_OFS:      rd_mux = {16'h0, fmax_r};
			`DRS_RAMP_OFS:      rd_mux = {16'h0, ramp_step_r};
			`DRS_LOCAL_REF_OFS: rd_mux = {16'h0, local_ref_r};
			default:            rd_mux = 32'h0000_0000;
		endcase
	end
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // drs_ref_select

`default_nettype wire

// ### verif/drs_panel_model.sv
// Panel key and remote command source for the selector bench
`timescale 1ns/100ps
`default_nettype none
module drs_panel_model
(
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [2:0] code,
	output wire logic       key_hand_on,
	output wire logic       key_off,
	output wire logic       key_auto_on,
	output wire logic       key_reset,
	output wire logic       key_up,
	output wire logic       key_down,
	output wire logic       remote_start,
	output wire logic       remote_stop
);
	// ----
	// Press decoder
	// ----
	// Each key follows go one clock later, so a held request holds the key high on every clock
	logic [7:0] pulse_r = 8'h00;
	always @(posedge aclk)
		pulse_r <= go ? (8'h01 << code) : 8'h00;
	assign {remote_stop, remote_start, key_down, key_up} = pulse_r[7:4];
	assign {key_reset, key_auto_on, key_off, key_hand_on} = pulse_r[3:0];
endmodule // drs_panel_model
`default_nettype wire

// ### verif/drs_ref_select_sva.sv
// Port checker for the reference-site selector
`timescale 1ns/100ps
`default_nettype none
module drs_ref_select_sva
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       key_hand_on,
	input wire logic       key_off,
	input wire logic       key_auto_on,
	input wire logic       key_reset,
	input wire logic       alarm_event,
	input wire logic       local_active,
	input wire logic       remote_active,
	input wire logic       pid_enable,
	input wire logic       motor_run,
	input wire logic       alarm_latched,
	input wire logic [1:0] mode_state,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----
	// Assertions
	// ----
	a_one_ref: assert property (local_active ^ remote_active)
		else $error("reference choice not one-hot");
	a_pid_remote: assert property (pid_enable |-> remote_active)
		else $error("pid on local reference");
	a_hand_key: assert property (key_hand_on |=> mode_state == 2'h0 || $stable(mode_state))
		else $error("hand key gave wrong mode");
	a_auto_key: assert property (key_auto_on && !key_hand_on |=> mode_state == 2'h2
		|| $stable(mode_state)) else $error("auto key gave wrong mode");
	a_off_memory: assert property (key_off && !key_hand_on && !key_auto_on
		|=> mode_state[1] == $past(mode_state[1])) else $error("off lost mode memory");
	a_mode_quiet: assert property (!key_hand_on && !key_off && !key_auto_on
		|=> $stable(mode_state)) else $error("mode moved without key");
	a_alarm_set: assert property (alarm_event |=> alarm_latched)
		else $error("alarm not latched");
	a_alarm_clr: assert property (key_reset && !alarm_event |=> !alarm_latched)
		else $error("reset key left alarm");
	a_alarm_stop: assert property ($rose(alarm_latched) |-> ##[0:2] !motor_run)
		else $error("motor runs with alarm");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	c_hand: cover property (key_hand_on ##2 local_active);
	c_pid: cover property ($rose(pid_enable));
	c_clear: cover property (alarm_latched ##1 !alarm_latched);
endmodule // drs_ref_select_sva
bind drs_ref_select drs_ref_select_sva drs_ref_select_sva_inst (.aclk(aclk),
	.aresetn(aresetn), .key_hand_on(key_hand_on), .key_off(key_off),
	.key_auto_on(key_auto_on), .key_reset(key_reset), .alarm_event(alarm_event),
	.local_active(local_active), .remote_active(remote_active), .pid_enable(pid_enable),
	.motor_run(motor_run), .alarm_latched(alarm_latched), .mode_state(mode_state),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// ### verif/tb_drs_ref_select.sv
// Self-checking bench for the reference-site selector
`timescale 1ns/100ps
`default_nettype none
module tb_drs_ref_select;
	localparam logic [15:0] RREF = 16'h1234;
	// Kept below the fmax used later so the PID path is told apart from the clamp
	localparam logic [15:0] PREF = 16'h0002;
	// Rows: control word, key, mode, local active, pid enable
	localparam logic [14:0] ROWS [8] = '{
		{8'h70, 3'h0, 2'h0, 1'b1, 1'b0}, {8'h7c, 3'h0, 2'h0, 1'b1, 1'b0},
		{8'h7c, 3'h1, 2'h1, 1'b1, 1'b0}, {8'h7c, 3'h2, 2'h2, 1'b0, 1'b1},
		{8'h70, 3'h1, 2'h3, 1'b0, 1'b0}, {8'h7e, 3'h2, 2'h2, 1'b1, 1'b0},
		{8'h7d, 3'h0, 2'h0, 1'b0, 1'b1}, {8'h71, 3'h0, 2'h0, 1'b0, 1'b0}};
	logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, alarm_event = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [2:0]  code = 3'h0;
	logic [1:0]  bresp, rresp, mode_state, r, wresp;
	logic [15:0] pid_setpoint, motor_ref;
	logic        awready, wready, bvalid, arready, rvalid, irq, motor_run, alarm_latched;
	logic        local_active, remote_active, pid_enable, kh, ko, ka, kr, ku, kd, rs, rp;
	int          fail_count = 0, compares = 0;

	always #4 aclk = ~aclk;

	drs_panel_model drs_panel_model_inst (.aclk(aclk), .go(go), .code(code),
		.key_hand_on(kh), .key_off(ko), .key_auto_on(ka), .key_reset(kr), .key_up(ku),
		.key_down(kd), .remote_start(rs), .remote_stop(rp));
	drs_ref_select #(.RAMP_DIV(2)) drs_ref_select_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.key_hand_on(kh), .key_off(ko), .key_auto_on(ka), .key_reset(kr), .key_up(ku),
		.key_down(kd), .remote_start(rs), .remote_stop(rp), .remote_ref(RREF),
		.alarm_event(alarm_event), .pid_out(PREF), .local_active(local_active),
		.remote_active(remote_active), .pid_enable(pid_enable), .pid_setpoint(pid_setpoint),
		.motor_run(motor_run), .motor_ref(motor_ref), .alarm_latched(alarm_latched),
		.mode_state(mode_state), .irq(irq));

	// ----
	// Tasks
	// ----
	task automatic print_verdict;
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Waits last until the answer; a silent slave is left to the watchdog
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		wresp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs_o);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		v = rdata;
		rs_o = rresp;
		rready <= 1'b0;
	endtask

	task automatic press(input logic [2:0] c);
		@(posedge aclk);
		go <= 1'b1;
		code <= c;
		@(posedge aclk);
		go <= 1'b0;
		repeat (5) @(negedge aclk);
	endtask

	// ----
	// Sequence
	// ----
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(negedge aclk);
		chk("mode", mode_state, 2'h3);
		chk("remote", remote_active, 1'b1);
		chk("irq", irq, 1'b0);
		rd(8'h00, d, r);
		chk("ctrl", d, 32'h70);
		foreach (ROWS[i])
		begin
			wr(8'h00, {24'h0, ROWS[i][14:7]});
			press(ROWS[i][6:4]);
			chk("mode", mode_state, ROWS[i][3:2]);
			chk("local", local_active, ROWS[i][1]);
			chk("remote", remote_active, !ROWS[i][1]);
			chk("pid", pid_enable, ROWS[i][0]);
			chk("setpoint", pid_setpoint, ROWS[i][0] ? RREF : 16'h0);
		end
		wr(8'h00, 32'h70);
		press(3'h2);
		chk("run", motor_run, 1'b0);
		press(3'h6);
		chk("run", motor_run, 1'b1);
		press(3'h7);
		chk("run", motor_run, 1'b0);
		wr(8'h0c, 32'h8);
		wr(8'h00, 32'h50);
		press(3'h1);
		chk("mode", mode_state, 2'h2);
		wr(8'h00, 32'h60);
		press(3'h0);
		chk("mode", mode_state, 2'h2);
		chk("irq", irq, 1'b1);
		rd(8'h08, d, r);
		chk("stat", d[3], 1'b1);
		wr(8'h08, 32'hf);
		@(negedge aclk);
		chk("irq", irq, 1'b0);
		wr(8'h00, 32'h72);
		wr(8'h1c, 32'h5);
		wr(8'h14, 32'h3);
		press(3'h0);
		press(3'h4);
		repeat (40) @(negedge aclk);
		chk("run", motor_run, 1'b1);
		chk("motor_ref", motor_ref, 16'h3);
		rd(8'h1c, d, r);
		chk("local_ref", d, 32'h6);
		press(3'h5);
		rd(8'h1c, d, r);
		chk("local_ref", d, 32'h5);
		@(posedge aclk);
		alarm_event <= 1'b1;
		@(posedge aclk);
		alarm_event <= 1'b0;
		repeat (4) @(negedge aclk);
		chk("alarm", alarm_latched, 1'b1);
		chk("run", motor_run, 1'b0);
		press(3'h3);
		chk("alarm", alarm_latched, 1'b0);
		rd(8'h20, d, r);
		chk("resp", r, 2'h2);
		chk("data", d, 32'h0);
		wr(8'h20, 32'h1);
		chk("bresp", wresp, 2'h2);
		wr(8'h14, 32'h3);
		chk("bresp", wresp, 2'h0);
		wr(8'h00, 32'h7d);
		repeat (40) @(negedge aclk);
		chk("pid", pid_enable, 1'b1);
		chk("motor_ref", motor_ref, PREF);
		print_verdict();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		fail_count++;
		print_verdict();
	end
endmodule // tb_drs_ref_select
`default_nettype wire
